/* File: rtl/wrc_top.sv */
// watchdog timer and reset-cause control behind an ahb-lite slave
`timescale 1ns/10ps
// Notes on behaviour
// - always-on mode runs with either valid key
// - register mode stops on disable key
// - register mode runs on enable key
// - bad key resets chip after 2-3 ticks
// - key-fault reset sets key fault flag
// - key flag: hardware sets, software zero clears
// - power-on loads enable key pattern
// - period code picks exponent 8 to 18
// - overflow in run: chip reset, expired flag
// - overflow asleep: flag, clear pc and sp
// - counter cleared by fault, clear, halt
// - qualified low supply resets, sets flag
// - four valid level codes choose threshold
// - bad level resets after 2-3 ticks, flags
// - bad level reset restores level register
// - genuine low-voltage reset keeps level
// - low-voltage reset off in power-down
// - low-voltage flag: hardware sets, zero clears
// - control bits six to three read zero
// - power-on: pc zero, ports high
// - sleep overflow leaves sleep flag set
// - counter ticks from low-speed rc clock
module wrc_top
  import wrc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic wdt_always_on,
  input wire logic low_speed_rc_osc,
  input wire logic low_supply_n,
  input wire logic power_down,
  input wire logic watchdog_clear_instr,
  input wire logic halt_instr,
  input wire logic sleep_mode,
  output logic chip_reset,
  output logic pc_sp_clear,
  output logic watchdog_expired_flag,
  output logic sleep_entry_flag,
  output logic idle_sysclk_keep
);
  import wrc_pkg::*;

  wrc_state_t s_q;
  wrc_state_t s_d;

  // ----------------------------------------
  // combinational helpers
  // ----------------------------------------
  logic tick;
  logic key_ok;
  logic key_run;
  logic lvl_ok;
  logic ovf;
  logic wr_go;
  logic rd_go;
  logic [4:0] exp_bit;
  logic [31:0] rd_val;
  logic [4:0] key;

  assign key = s_q.wdog[7:WRC_KEY_LSB];
  assign tick = s_q.tick_sync[1] & ~s_q.tick_sync[2];
  assign key_ok = (key == WRC_KEY_ENABLE) || (key == WRC_KEY_DISABLE);
  // register mode runs on the enable pattern only
  assign key_run = wdt_always_on ? key_ok : (key == WRC_KEY_ENABLE);
  assign lvl_ok = (s_q.level == WRC_LEVEL_A) || (s_q.level == WRC_LEVEL_B) ||
                  (s_q.level == WRC_LEVEL_C) || (s_q.level == WRC_LEVEL_D);
  assign wr_go = s_q.dphase & s_q.dwrite;
  assign rd_go = hsel & hready & htrans[1] & ~hwrite;

  always_comb begin
    unique case (s_q.wdog[2:0])
      3'h0: exp_bit = 5'h08;
      3'h1: exp_bit = 5'h0a;
      3'h2: exp_bit = 5'h0c;
      3'h3: exp_bit = 5'h0e;
      3'h4: exp_bit = 5'h0f;
      3'h5: exp_bit = 5'h10;
      3'h6: exp_bit = 5'h11;
      3'h7: exp_bit = 5'h12;
    endcase
  end

  // overflow when every bit below the selected exponent is set at a tick
  always_comb begin
    logic [WRC_CNT_W-1:0] mask;
    mask = '0;
    for (int i = 0; i < WRC_CNT_W; i++) begin
      if (i < int'(exp_bit)) begin
        mask[i] = 1'b1;
      end
    end
    ovf = tick & key_run & ((s_q.cnt & mask) == mask);
  end

  always_comb begin
    rd_val = 32'h0;
    unique case (haddr[7:0])
      WRC_ADDR_WDOG: rd_val = {24'h0, s_q.wdog};
      // bits six to three are not stored and read zero
      WRC_ADDR_CAUSE: rd_val = {24'h0, s_q.idle_sysclk_keep, 4'h0, s_q.lvr_flag,
                                s_q.lvl_flag, s_q.key_flag};
      WRC_ADDR_LEVEL: rd_val = {24'h0, s_q.level};
      WRC_ADDR_STATE: rd_val = {30'h0, s_q.expired, s_q.sleep_entry};
      default: rd_val = 32'h0;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic key_fault;
    logic lvl_fault;
    logic bo_fire;
    key_fault = 1'b0;
    lvl_fault = 1'b0;
    bo_fire = 1'b0;
    s_d = s_q;
    s_d.tick_sync = {s_q.tick_sync[1:0], low_speed_rc_osc};
    s_d.low_sync = {s_q.low_sync[0], ~low_supply_n};
    s_d.pwrdn_sync = {s_q.pwrdn_sync[0], power_down};
    s_d.pc_sp_clr = 1'b0;
    s_d.hrdata = 32'h0;
    s_d.dphase = hsel & hready & htrans[1];
    s_d.dwrite = hwrite;
    s_d.daddr = haddr[7:0];
    if (rd_go) begin
      s_d.hrdata = rd_val;
    end

    // software writes; a zero write clears flags, a one leaves them
    if (wr_go) begin
      unique case (s_q.daddr)
        WRC_ADDR_WDOG: s_d.wdog = hwdata[7:0];
        WRC_ADDR_LEVEL: s_d.level = hwdata[7:0];
        WRC_ADDR_CAUSE: begin
          s_d.idle_sysclk_keep = hwdata[WRC_IDLE_KEEP_BIT];
          s_d.lvr_flag = s_q.lvr_flag & hwdata[WRC_LVR_FLAG_BIT];
          s_d.lvl_flag = s_q.lvl_flag & hwdata[WRC_LVL_FLAG_BIT];
          s_d.key_flag = s_q.key_flag & hwdata[WRC_KEY_FLAG_BIT];
        end
        WRC_ADDR_STATE: s_d.sleep_entry = s_q.sleep_entry & hwdata[0];
        default: ;
      endcase
    end

    // watchdog count, cleared by the clear or halt instruction
    if (watchdog_clear_instr || halt_instr || !key_run) begin
      s_d.cnt = '0;
    end else if (tick) begin
      s_d.cnt = s_q.cnt + 18'h1;
    end
    if (halt_instr) begin
      s_d.sleep_entry = 1'b1;
      s_d.expired = 1'b0;
    end

    // bad key or level waits for the second slow tick
    if (key_ok) begin
      s_d.key_ticks = 2'h0;
    end else if (tick) begin
      s_d.key_ticks = s_q.key_ticks + 2'h1;
    end
    key_fault = !key_ok && tick && (s_q.key_ticks == 2'(WRC_FAULT_TICKS - 1));
    if (lvl_ok) begin
      s_d.lvl_ticks = 2'h0;
    end else if (tick) begin
      s_d.lvl_ticks = s_q.lvl_ticks + 2'h1;
    end
    lvl_fault = !lvl_ok && tick && (s_q.lvl_ticks == 2'(WRC_FAULT_TICKS - 1));

    // low supply must persist the minimum time; ignored in power-down
    if (!s_q.low_sync[1] || s_q.pwrdn_sync[1]) begin
      s_d.bo_cnt = 6'h0;
    end else if (s_q.bo_cnt != 6'(WRC_BROWNOUT_CYC)) begin
      s_d.bo_cnt = s_q.bo_cnt + 6'h1;
    end
    bo_fire = s_q.bo_cnt == 6'(WRC_BROWNOUT_CYC - 1);

    // ovf asleep: flag only, pc and sp cleared, sleep flag kept
    if (ovf && sleep_mode) begin
      s_d.expired = 1'b1;
      s_d.pc_sp_clr = 1'b1;
      s_d.cnt = '0;
    end

    if (key_fault || lvl_fault || bo_fire || (ovf && !sleep_mode)) begin
      s_d.chip_rst = 1'b1;
      s_d.rst_cnt = 3'(WRC_RST_PULSE_CYC);
      // control state returns to power-on values except level on a low-voltage reset; flags set win over clears
      s_d.wdog = WRC_WDOG_RST;
      s_d.cnt = '0;
      s_d.key_ticks = 2'h0;
      s_d.lvl_ticks = 2'h0;
      s_d.idle_sysclk_keep = 1'b0;
      if (key_fault) begin
        s_d.key_flag = 1'b1;
      end
      if (lvl_fault) begin
        s_d.lvl_flag = 1'b1;
        s_d.level = WRC_LEVEL_RST;
      end else if (!bo_fire) begin
        s_d.level = WRC_LEVEL_RST;
      end
      // genuine low-voltage reset keeps the level
      if (bo_fire) begin
        s_d.lvr_flag = 1'b1;
      end
      if (ovf && !sleep_mode) begin
        s_d.expired = 1'b1;
      end else if (!bo_fire) begin
        s_d.expired = 1'b0;
      end
    end else if (s_q.rst_cnt != 3'h0) begin
      s_d.rst_cnt = s_q.rst_cnt - 3'h1;
      s_d.chip_rst = s_q.rst_cnt != 3'h1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.wdog <= WRC_WDOG_RST;
      s_q.level <= WRC_LEVEL_RST;
      // chip reset pulse drives pc to zero and ports to inputs outside
      s_q.chip_rst <= 1'b1;
      s_q.rst_cnt <= 3'(WRC_RST_PULSE_CYC);
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign chip_reset = s_q.chip_rst;
  assign pc_sp_clear = s_q.pc_sp_clr;
  assign watchdog_expired_flag = s_q.expired;
  assign sleep_entry_flag = s_q.sleep_entry;
  assign idle_sysclk_keep = s_q.idle_sysclk_keep;
endmodule

/* File: shared/wrc_pkg.sv */
// package of constants and types for the watchdog and reset-control block
package wrc_pkg;
  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [7:0] WRC_ADDR_WDOG = 8'h00;
  localparam logic [7:0] WRC_ADDR_CAUSE = 8'h04;
  localparam logic [7:0] WRC_ADDR_LEVEL = 8'h08;
  localparam logic [7:0] WRC_ADDR_CONFIG = 8'h0c;
  localparam logic [7:0] WRC_ADDR_STATE = 8'h10;
  // ----------------------------------------
  // reset values, key patterns and level codes
  // ----------------------------------------
  localparam logic [7:0] WRC_WDOG_RST = 8'h53;
  localparam logic [7:0] WRC_LEVEL_RST = 8'h55;
  localparam logic [4:0] WRC_KEY_ENABLE = 5'h0a;
  localparam logic [4:0] WRC_KEY_DISABLE = 5'h15;
  localparam logic [7:0] WRC_LEVEL_A = 8'h55;
  localparam logic [7:0] WRC_LEVEL_B = 8'h33;
  localparam logic [7:0] WRC_LEVEL_C = 8'h99;
  localparam logic [7:0] WRC_LEVEL_D = 8'haa;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int WRC_KEY_LSB = 3;
  localparam int WRC_IDLE_KEEP_BIT = 7;
  localparam int WRC_LVR_FLAG_BIT = 2;
  localparam int WRC_LVL_FLAG_BIT = 1;
  localparam int WRC_KEY_FLAG_BIT = 0;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int WRC_CLK_NS = 25;
  localparam int WRC_BROWNOUT_MIN_NS = 1000;
  localparam int WRC_BROWNOUT_CYC = (WRC_BROWNOUT_MIN_NS + WRC_CLK_NS - 1) / WRC_CLK_NS;
  localparam int WRC_FAULT_TICKS = 2;
  localparam int WRC_RST_PULSE_CYC = 4;
  localparam int WRC_CNT_W = 18;

  typedef struct packed {
    logic [7:0] wdog;
    logic [7:0] level;
    logic idle_sysclk_keep;
    logic lvr_flag;
    logic lvl_flag;
    logic key_flag;
    logic expired;
    logic sleep_entry;
    logic [WRC_CNT_W-1:0] cnt;
    logic [1:0] key_ticks;
    logic [1:0] lvl_ticks;
    logic [5:0] bo_cnt;
    logic [2:0] rst_cnt;
    logic chip_rst;
    logic pc_sp_clr;
    logic [2:0] tick_sync;
    logic [1:0] low_sync;
    logic [1:0] pwrdn_sync;
    logic dphase;
    logic dwrite;
    logic [7:0] daddr;
    logic [31:0] hrdata;
  } wrc_state_t;
endpackage

/* File: testbench/wrc_assertions.sv */
// port-level checks for the watchdog and reset-control block
`timescale 1ns/10ps
module wrc_assertions (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic low_supply_n,
  input wire logic power_down,
  input wire logic halt_instr,
  input wire logic sleep_mode,
  input wire logic chip_reset,
  input wire logic pc_sp_clear,
  input wire logic watchdog_expired_flag,
  input wire logic sleep_entry_flag
);
  import wrc_pkg::*;
  // run length of a low supply that power-down does not mask
  logic [5:0] lo_q;
  always_ff @(posedge mclk) begin
    if (!reset_n || low_supply_n || power_down) lo_q <= 6'h00;
    else if (lo_q != 6'h3f) lo_q <= lo_q + 6'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_reset_len: assert property ($rose(chip_reset) |-> chip_reset[*4] ##1 !chip_reset)
    else $error("chip reset pulse length wrong");
  a_run_expiry: assert property ($rose(watchdog_expired_flag) && !sleep_mode |-> ##[0:3] chip_reset)
    else $error("overflow in run mode gave no chip reset");
  a_sleep_pulse: assert property (pc_sp_clear |=> !pc_sp_clear)
    else $error("pc and sp clear longer than one cycle");
  a_sleep_only: assert property (pc_sp_clear |-> $past(sleep_mode) && !chip_reset)
    else $error("pc and sp clear outside sleep");
  a_sleep_flags: assert property (pc_sp_clear |-> watchdog_expired_flag && sleep_entry_flag)
    else $error("sleep overflow flags wrong");
  a_halt_flags: assert property (halt_instr |=> sleep_entry_flag && !watchdog_expired_flag)
    else $error("halt flags wrong");
  a_brownout: assert property (lo_q == 6'd44 |-> ##[0:4] chip_reset)
    else $error("long low supply gave no reset");
  a_unused_zero: assert property (hsel && hready && htrans[1] && !hwrite
    && haddr[7:0] == WRC_ADDR_CAUSE |=> hrdata[31:8] == 24'h0 && hrdata[6:3] == 4'h0)
    else $error("unimplemented cause bits not zero");
  c_chip: cover property ($rose(chip_reset));
  c_sleep: cover property (pc_sp_clear);
  c_halt: cover property (halt_instr);
endmodule
bind wrc_top wrc_assertions i_chk (.*);

/* File: testbench/test_watchdog_reset_control.sv */
// self-checking bench for the watchdog and reset-control block
`timescale 1ns/10ps
module test_watchdog_reset_control;
  import wrc_pkg::*;
  logic mclk, reset_n, hsel, hwrite, hready, hreadyout, hresp, wdt_always_on;
  logic low_speed_rc_osc, low_supply_n, power_down, watchdog_clear_instr, halt_instr;
  logic sleep_mode, chip_reset, pc_sp_clear, watchdog_expired_flag, sleep_entry_flag;
  logic idle_sysclk_keep;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int num_errors = 0, checks = 0, tk = 0, rc = 0;
  assign hready = hreadyout;
  always #12.5 mclk = ~mclk;
  // slow clock of 8 mclk periods keeps long time-outs affordable
  always #100 low_speed_rc_osc = ~low_speed_rc_osc;
  // count a slow tick once the two-flop synchroniser has passed it to the counter logic
  always @(posedge low_speed_rc_osc) tk <= #50 tk + 1;
  always @(posedge chip_reset) rc++;
  wrc_top i_dut (.mclk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .wdt_always_on, .low_speed_rc_osc, .low_supply_n,
    .power_down, .watchdog_clear_instr, .halt_instr, .sleep_mode, .chip_reset,
    .pc_sp_clear, .watchdog_expired_flag, .sleep_entry_flag, .idle_sysclk_keep);
  task automatic tally_and_finish();
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // read data is taken before the edge's own updates land
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(n, e, r);
  endtask
  task automatic clr();
    @(posedge mclk) watchdog_clear_instr <= 1'b1;
    repeat (10) @(posedge mclk);
    watchdog_clear_instr <= 1'b0;
  endtask
  task automatic wrst(input int lo, input int hi);
    int t0;
    int n;
    t0 = tk;
    n = 0;
    while (chip_reset !== 1'b1 && n < hi * 8 + 40) begin
      @(posedge mclk);
      n++;
    end
    chk("reset_ticks", 32'h1, 32'(chip_reset === 1'b1 && tk - t0 >= lo && tk - t0 <= hi));
    repeat (8) @(posedge mclk);
  endtask
  task automatic low(input int n);
    @(posedge mclk) low_supply_n <= 1'b0;
    repeat (n) @(posedge mclk);
    low_supply_n <= 1'b1;
    repeat (50) @(posedge mclk);
  endtask
  task automatic t_regs();
    rd("wdog", WRC_ADDR_WDOG, 32'h53);
    rd("level", WRC_ADDR_LEVEL, 32'h55);
    rd("cause", WRC_ADDR_CAUSE, 32'h0);
    rd("unmapped", WRC_ADDR_CONFIG, 32'h0);
    wr(WRC_ADDR_CAUSE, 32'hff);
    rd("cause", WRC_ADDR_CAUSE, 32'h80);
    chk("idle_keep", 32'h1, {31'h0, idle_sysclk_keep});
    wr(WRC_ADDR_CAUSE, 32'h0);
  endtask
  task automatic t_wdt();
    int r0;
    wdt_always_on <= 1'b0;
    wr(WRC_ADDR_WDOG, 32'ha8);
    clr();
    r0 = rc;
    repeat (300) @(posedge low_speed_rc_osc);
    chk("stopped", r0, rc);
    wr(WRC_ADDR_WDOG, 32'h50);
    clr();
    repeat (200) @(posedge low_speed_rc_osc);
    clr();
    wrst(254, 257);
    rd("state", WRC_ADDR_STATE, 32'h2);
    wdt_always_on <= 1'b1;
    wr(WRC_ADDR_WDOG, 32'ha9);
    clr();
    wrst(1022, 1025);
  endtask
  task automatic t_faults();
    logic [31:0] lv[4] = '{32'h55, 32'h33, 32'h99, 32'haa};
    int r0;
    wdt_always_on <= 1'b0;
    wr(WRC_ADDR_WDOG, 32'h00);
    wrst(2, 3);
    wr(WRC_ADDR_WDOG, 32'ha8);
    rd("cause", WRC_ADDR_CAUSE, 32'h1);
    wr(WRC_ADDR_CAUSE, 32'h0);
    rd("cause", WRC_ADDR_CAUSE, 32'h0);
    r0 = rc;
    for (int i = 0; i < 4; i++) begin
      wr(WRC_ADDR_LEVEL, lv[i]);
      rd("level", WRC_ADDR_LEVEL, lv[i]);
    end
    chk("level_ok", r0, rc);
    wr(WRC_ADDR_LEVEL, 32'h12);
    wrst(2, 3);
    rd("level", WRC_ADDR_LEVEL, 32'h55);
    rd("cause", WRC_ADDR_CAUSE, 32'h2);
    wr(WRC_ADDR_CAUSE, 32'h0);
  endtask
  task automatic t_brown();
    int r0;
    wr(WRC_ADDR_LEVEL, 32'h99);
    r0 = rc;
    low(20);
    chk("short_low", r0, rc);
    power_down <= 1'b1;
    low(100);
    power_down <= 1'b0;
    chk("pd_low", r0, rc);
    low(60);
    chk("long_low", r0 + 1, rc);
    rd("cause", WRC_ADDR_CAUSE, 32'h4);
    rd("level", WRC_ADDR_LEVEL, 32'h99);
    wr(WRC_ADDR_CAUSE, 32'h0);
    rd("cause", WRC_ADDR_CAUSE, 32'h0);
  endtask
  task automatic t_sleep();
    int r0;
    int n;
    wr(WRC_ADDR_WDOG, 32'h50);
    @(posedge mclk) halt_instr <= 1'b1;
    @(posedge mclk) halt_instr <= 1'b0;
    sleep_mode <= 1'b1;
    @(posedge mclk);
    chk("sleep_flag", 32'h1, {31'h0, sleep_entry_flag});
    chk("expired", 32'h0, {31'h0, watchdog_expired_flag});
    r0 = rc;
    n = 0;
    while (pc_sp_clear !== 1'b1 && n < 2200) begin
      @(posedge mclk);
      n++;
    end
    chk("pc_sp_clear", 32'h1, {31'h0, pc_sp_clear});
    chk("expired", 32'h1, {31'h0, watchdog_expired_flag});
    repeat (8) @(posedge mclk);
    chk("no_reset", r0, rc);
    sleep_mode <= 1'b0;
    wr(WRC_ADDR_WDOG, 32'ha8);
  endtask
  initial begin
    {mclk, low_speed_rc_osc, reset_n, hsel, hwrite, power_down} = 6'h00;
    {wdt_always_on, watchdog_clear_instr, halt_instr, sleep_mode} = 4'h0;
    {haddr, hwdata, htrans, hsize, low_supply_n} = {64'h0, 2'b00, 3'b010, 1'b1};
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    t_regs();
    t_wdt();
    t_faults();
    t_brown();
    t_sleep();
    tally_and_finish();
  end
  initial begin
    #2ms;
    num_errors++;
    tally_and_finish();
  end
endmodule
